// File: hw/simd_fp_pkg.sv
// constants shared by the simd floating-point register file
package simd_fp_pkg;

  // ==========================================================================
  // vector register file geometry
  localparam int unsigned VEC_W        = 128;
  localparam int unsigned VEC_BYTES    = 16;
  localparam int unsigned NUM_BASE     = 8;
  localparam int unsigned NUM_REGS     = 16;
  localparam int unsigned IDX_W        = 4;
  localparam int unsigned LANE_W       = 32;
  localparam int unsigned QW_W         = 64;

  // ==========================================================================
  // control/status register layout
  localparam int unsigned CSR_W        = 32;
  localparam int unsigned FLAG_LO      = 0;
  localparam int unsigned FLAG_N       = 6;
  localparam int unsigned DAZ_BIT      = 6;
  localparam int unsigned MASK_LO      = 7;
  localparam int unsigned RC_LO        = 13;
  localparam int unsigned RC_W         = 2;
  localparam int unsigned FZ_BIT       = 15;
  localparam int unsigned RSV_LO       = 16;
  localparam int unsigned RSV_W        = 16;

  // flag order inside the six-bit flag and mask groups
  localparam int unsigned EXC_INVALID  = 0;
  localparam int unsigned EXC_DENORMAL = 1;
  localparam int unsigned EXC_DIVZERO  = 2;
  localparam int unsigned EXC_OVERFLOW = 3;
  localparam int unsigned EXC_UNDERFLOW = 4;
  localparam int unsigned EXC_PRECISION = 5;

  localparam logic [CSR_W-1:0] CSR_RESET = 32'h0000_1f80;
  localparam logic [15:0]      RSV_ZERO  = 16'h0000;
  localparam logic [5:0]       ALL_MASKED = 6'h3f;

  // alignment: low four address bits of a 128-bit packed operand
  localparam int unsigned ALIGN_BITS   = 4;
  localparam int unsigned ADDR_W       = 64;
  localparam logic [ALIGN_BITS-1:0] ALIGN_ZERO = 4'h0;

  // ==========================================================================
  // rounding modes
  typedef enum logic [RC_W-1:0] {
    RC_NEAREST = 2'h0,
    RC_DOWN    = 2'h1,
    RC_UP      = 2'h2,
    RC_ZERO    = 2'h3
  } round_mode_t;

  // transfer sizes for vector loads and stores
  typedef enum logic [1:0] {
    XFER_32  = 2'h0,
    XFER_64  = 2'h1,
    XFER_128 = 2'h2
  } xfer_size_t;

  // writer of the control/status register
  typedef enum logic [1:0] {
    CSR_SRC_LOAD    = 2'h0,
    CSR_SRC_RESTORE = 2'h1
  } csr_src_t;

endpackage

// File: hw/simd_fp_regs.sv
// vector data registers and simd floating-point control/status register
// ============================================================================
`timescale 1ns/1ps

module simd_fp_regs
  import simd_fp_pkg::*;
#(
  parameter bit DAZ_SUPPORTED = 1'b1
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  // decode context
  input  wire logic                  long_mode,
  input  wire logic                  register_extension_prefix,
  input  wire logic                  ext_meaningful,
  input  wire logic                  operand_width_prefix_bit,
  // read ports
  input  wire logic [IDX_W-2:0]      rd_a_idx,
  input  wire logic                  rd_a_ext,
  input  wire logic [IDX_W-2:0]      rd_b_idx,
  input  wire logic                  rd_b_ext,
  // write port from execution or memory load
  input  wire logic                  wr_en,
  input  wire logic [IDX_W-2:0]      wr_idx,
  input  wire logic                  wr_ext,
  input  wire logic [1:0]            wr_size,
  input  wire logic                  wr_scalar,
  input  wire logic [VEC_W-1:0]      wr_data,
  input  wire logic [ADDR_W-1:0]     mem_addr,
  input  wire logic                  mem_access,
  input  wire logic                  aligned_packed_move,
  // control/status access
  input  wire logic                  csr_wr,
  input  wire logic [1:0]            csr_src,
  input  wire logic [CSR_W-1:0]      csr_wdata,
  // exceptions detected by execution
  input  wire logic                  exc_valid,
  input  wire logic [FLAG_N-1:0]     exc_raw,
  input  wire logic                  exc_underflow_tiny,
  // outputs
  output logic [VEC_W-1:0]           rd_a_data,
  output logic [VEC_W-1:0]           rd_b_data,
  output logic [VEC_BYTES*8-1:0]     store_bytes,
  output logic [CSR_W-1:0]           simd_fp_control_status,
  output logic [CSR_W-1:0]           writable_bits_mask,
  output logic [RC_W-1:0]            rounding_control_field,
  output logic                       flush_to_zero_bit,
  output logic                       denormals_as_zero_bit,
  output logic                       flush_result_zero,
  output logic                       gpr_is_64,
  output logic                       general_protection_fault,
  output logic                       simd_fp_trap
);

  // ==========================================================================
  // index decode
  function automatic logic [IDX_W-1:0] full_idx(input logic [IDX_W-2:0] low, input logic ext);
    // extension bit only counts with a meaningful prefix in 64-bit mode
    full_idx = {ext & long_mode & register_extension_prefix & ext_meaningful, low};
  endfunction

  logic [VEC_W-1:0] vec_q [NUM_REGS];   // private storage, no aliasing
  logic [CSR_W-1:0] csr_q;
  logic [IDX_W-1:0] wr_full;
  logic [VEC_W-1:0] old_w;
  logic [VEC_W-1:0] merged;
  logic             align_bad;
  logic             csr_bad;
  logic [FLAG_N-1:0] masks;
  logic [FLAG_N-1:0] exc_eff;
  logic             ftz_now;

  assign wr_full = full_idx(wr_idx, wr_ext);
  assign old_w   = vec_q[wr_full];
  assign masks   = csr_q[MASK_LO +: FLAG_N];

  // ==========================================================================
  // alignment check; addresses come from general registers only
  assign align_bad = mem_access & aligned_packed_move &
                     (mem_addr[ALIGN_BITS-1:0] != ALIGN_ZERO);

  // ==========================================================================
  // write merge by transfer size; scalar keeps upper lanes
  always_comb begin
    merged = old_w;
    if (wr_scalar || wr_size == XFER_32) begin
      merged[LANE_W-1:0] = wr_data[LANE_W-1:0];
    end else if (wr_size == XFER_64) begin
      merged[QW_W-1:0] = wr_data[QW_W-1:0];
    end else begin
      merged = wr_data;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        vec_q[i] <= '0;
      end
    end else if (wr_en && !align_bad) begin
      vec_q[wr_full] <= merged;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_a_data   <= '0;
      rd_b_data   <= '0;
      store_bytes <= '0;
    end else begin
      rd_a_data   <= vec_q[full_idx(rd_a_idx, rd_a_ext)];
      rd_b_data   <= vec_q[full_idx(rd_b_idx, rd_b_ext)];
      // byte 0 of memory is register bits 7:0, held in store_bytes[7:0]
      store_bytes <= vec_q[full_idx(rd_a_idx, rd_a_ext)];
    end
  end

  // ==========================================================================
  // control/status register
  assign csr_bad = csr_wr &&
                   ((csr_wdata[RSV_LO +: RSV_W] != RSV_ZERO) ||
                    (!DAZ_SUPPORTED && csr_wdata[DAZ_BIT]));

  // flush-to-zero only when underflow masked; denormals-as-zero hides flag
  assign ftz_now = exc_valid && exc_underflow_tiny && csr_q[FZ_BIT] &&
                   masks[EXC_UNDERFLOW];

  always_comb begin
    exc_eff = exc_valid ? exc_raw : '0;
    if (csr_q[DAZ_BIT]) begin
      exc_eff[EXC_DENORMAL] = 1'b0;
    end
    if (ftz_now) begin
      exc_eff[EXC_UNDERFLOW] = 1'b1;
      exc_eff[EXC_PRECISION] = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      csr_q <= CSR_RESET;
    end else if (csr_wr && !csr_bad) begin
      // load or restore replaces all; a same-cycle event still sets its flag
      csr_q <= csr_wdata | {{(CSR_W-FLAG_N){1'b0}}, exc_eff};
    end else begin
      csr_q[FLAG_LO +: FLAG_N] <= csr_q[FLAG_LO +: FLAG_N] | exc_eff;
    end
  end

  // ==========================================================================
  // outputs, registered
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      simd_fp_control_status   <= CSR_RESET;
      // the writable mask is fixed by the build, so it reads correctly from reset on
      writable_bits_mask       <= {RSV_ZERO, 16'hffff} & ~({{(CSR_W-1){1'b0}}, !DAZ_SUPPORTED} << DAZ_BIT);
      rounding_control_field   <= RC_NEAREST;
      flush_to_zero_bit        <= 1'b0;
      denormals_as_zero_bit    <= 1'b0;
      flush_result_zero        <= 1'b0;
      gpr_is_64                <= 1'b0;
      general_protection_fault <= 1'b0;
      simd_fp_trap             <= 1'b0;
    end else begin
      simd_fp_control_status   <= csr_q;
      writable_bits_mask       <= {RSV_ZERO, 16'hffff} & ~({{(CSR_W-1){1'b0}}, !DAZ_SUPPORTED} << DAZ_BIT);
      rounding_control_field   <= csr_q[RC_LO +: RC_W];
      flush_to_zero_bit        <= csr_q[FZ_BIT];
      denormals_as_zero_bit    <= csr_q[DAZ_BIT];
      flush_result_zero        <= ftz_now;
      gpr_is_64                <= long_mode & register_extension_prefix & operand_width_prefix_bit;
      general_protection_fault <= csr_bad | (wr_en & align_bad);
      // trap only on a detected unmasked exception, never on a csr write
      simd_fp_trap             <= |(exc_eff & ~masks);
    end
  end

endmodule

// File: verification/simd_fp_regs_props.sv
// port assertions for the simd fp register file
`timescale 1ns/1ps
module simd_fp_regs_props
  import simd_fp_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              csr_wr,
  input wire logic [CSR_W-1:0]  csr_wdata,
  input wire logic              exc_valid,
  input wire logic              wr_en,
  input wire logic              mem_access,
  input wire logic              aligned_packed_move,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [VEC_W-1:0]  rd_a_data,
  input wire logic [VEC_W-1:0]  store_bytes,
  input wire logic [CSR_W-1:0]  simd_fp_control_status,
  input wire logic [RC_W-1:0]   rounding_control_field,
  input wire logic              flush_to_zero_bit,
  input wire logic              denormals_as_zero_bit,
  input wire logic              general_protection_fault,
  input wire logic              simd_fp_trap
);
  // ========
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_rsv_write_faults: assert property (csr_wr && csr_wdata[31:16] != 16'h0 |-> ##[1:2] general_protection_fault)
    else $error("reserved write not faulted");
  a_rsv_stay_zero: assert property (simd_fp_control_status[31:16] == RSV_ZERO)
    else $error("reserved bits set");
  // a flag may only drop after a software write to the register
  a_flag_sticky: assert property (|($past(simd_fp_control_status[5:0]) & ~simd_fp_control_status[5:0])
    |-> $past(csr_wr) || $past(csr_wr, 2) || $past(csr_wr, 3))
    else $error("flag dropped");
  a_trap_cause: assert property (simd_fp_trap |-> $past(exc_valid) || $past(exc_valid, 2))
    else $error("trap without exception");
  a_misalign_faults: assert property (wr_en && mem_access && aligned_packed_move && mem_addr[3:0] != 4'h0
    |-> ##[1:2] general_protection_fault)
    else $error("misaligned move not faulted");
  a_reset_value: assert property ($fell(reset) |-> simd_fp_control_status == CSR_RESET)
    else $error("bad reset value");
  a_ctrl_mirror: assert property (rounding_control_field == simd_fp_control_status[14:13]
    && flush_to_zero_bit == simd_fp_control_status[15] && denormals_as_zero_bit == simd_fp_control_status[6])
    else $error("control fields differ");
  a_store_view: assert property (store_bytes == rd_a_data)
    else $error("store bytes differ");
endmodule

bind simd_fp_regs simd_fp_regs_props u_simd_fp_regs_props (.mclk, .reset, .csr_wr, .csr_wdata, .exc_valid, .wr_en,
  .mem_access, .aligned_packed_move, .mem_addr, .rd_a_data, .store_bytes, .simd_fp_control_status,
  .rounding_control_field, .flush_to_zero_bit, .denormals_as_zero_bit, .general_protection_fault, .simd_fp_trap);

// File: verification/exec_unit_model.sv
// execution-side model reporting detected exceptions
`timescale 1ns/1ps
module exec_unit_model
  import simd_fp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              go,
  input  wire logic [FLAG_N-1:0] flags,
  output logic                   exc_valid,
  output logic [FLAG_N-1:0]      exc_raw,
  output logic                   exc_underflow_tiny
);
  initial begin
    exc_valid = 1'b0;
    exc_raw = 6'h2a;
    exc_underflow_tiny = 1'b0;
  end
  // idle flag lines toggle so a stale report is never read as fresh
  always @(posedge mclk) begin
    exc_valid <= go;
    exc_raw <= go ? flags : ~exc_raw;
    exc_underflow_tiny <= go & flags[EXC_UNDERFLOW];
  end
endmodule

// File: verification/tb_simd_fp_regs.sv
// self-checking bench for the simd fp register file
`timescale 1ns/1ps
module tb_simd_fp_regs;
  import simd_fp_pkg::*;
  typedef struct {logic [2:0] i; logic [1:0] s; logic [VEC_W-1:0] d; logic [VEC_W-1:0] e;} row_t;
  localparam logic [VEC_W-1:0] PA = 128'h0f0e0d0c_0b0a0908_07060504_03020100;
  localparam logic [63:0]      PQ = 64'h11112222_33334444;
  logic mclk, reset, long_mode, register_extension_prefix, ext_meaningful, operand_width_prefix_bit;
  logic rd_a_ext, rd_b_ext, wr_en, wr_ext, wr_scalar, mem_access, aligned_packed_move, csr_wr, exc_go;
  logic exc_valid, exc_underflow_tiny, flush_to_zero_bit, denormals_as_zero_bit, flush_result_zero;
  logic gpr_is_64, general_protection_fault, simd_fp_trap;
  logic [2:0]        rd_a_idx, rd_b_idx, wr_idx;
  logic [1:0]        wr_size, csr_src, rounding_control_field;
  logic [VEC_W-1:0]  wr_data, rd_a_data, rd_b_data, store_bytes;
  logic [ADDR_W-1:0] mem_addr;
  logic [CSR_W-1:0]  csr_wdata, simd_fp_control_status, writable_bits_mask;
  logic [5:0]        exc_raw, exc_flags;
  int                error_cnt, n_checks, cyc, gpf_cnt, trap_cnt, ftz_cnt, g, t;
  row_t rows[5] = '{'{3'h1, XFER_128, PA, PA}, '{3'h1, XFER_32, {4{32'hc3c2c1c0}}, {PA[127:32], 32'hc3c2c1c0}},
    '{3'h1, XFER_64, {2{PQ}}, {PA[127:64], PQ}}, '{3'h7, XFER_128, ~PA, ~PA},
    '{3'h0, XFER_128, {4{32'h3f800000}}, {4{32'h3f800000}}}};

  simd_fp_regs u_simd_fp_regs (.*);
  exec_unit_model u_exec_unit_model (.mclk, .go(exc_go), .flags(exc_flags), .exc_valid, .exc_raw,
    .exc_underflow_tiny);

  // ========
  // clock, pulse counters and hang guard
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    gpf_cnt += int'(general_protection_fault === 1'b1);
    trap_cnt += int'(simd_fp_trap === 1'b1);
    ftz_cnt += int'(flush_result_zero === 1'b1);
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ========
  // tasks
  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // wide enough for three full registers side by side
  task automatic chk(logic [511:0] got, logic [511:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h", $time, got);
    end
  endtask
  task automatic vwr(logic [2:0] i, logic e, logic [1:0] s, logic [VEC_W-1:0] d);
    {wr_idx, wr_ext, wr_size, wr_data, wr_en} = {i, e, s, d, 1'b1};
    tick();
    wr_en = 1'b0;
  endtask
  task automatic vrd(logic [2:0] i, logic e);
    {rd_a_idx, rd_b_idx, rd_a_ext} = {i, i, e};
    tick();
  endtask
  task automatic cwr(logic [CSR_W-1:0] v);
    {csr_wdata, csr_wr} = {v, 1'b1};
    tick();
    csr_wr = 1'b0;
    tick(2);
  endtask
  task automatic raise(logic [5:0] f);
    {exc_flags, exc_go} = {f, 1'b1};
    tick();
    exc_go = 1'b0;
    tick(3);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ========
  // main sequence
  initial begin
    {long_mode, register_extension_prefix, ext_meaningful, operand_width_prefix_bit, rd_a_ext, rd_b_ext} = '0;
    {wr_en, wr_ext, wr_scalar, mem_access, aligned_packed_move, csr_wr, exc_go, exc_flags, csr_src} = '0;
    {rd_a_idx, rd_b_idx, wr_idx, wr_size, wr_data, mem_addr, csr_wdata} = '0;
    reset = 1'b1;
    tick(8);
    reset = 1'b0;
    chk(simd_fp_control_status, CSR_RESET);
    chk({writable_bits_mask, flush_to_zero_bit, denormals_as_zero_bit}, {32'h0000ffff, 2'h0});
    foreach (rows[r]) begin
      vwr(rows[r].i, 1'b0, rows[r].s, rows[r].d);
      vrd(rows[r].i, 1'b0);
      chk({rd_a_data, rd_b_data, store_bytes}, {rows[r].e, rows[r].e, rows[r].e});
    end
    {long_mode, register_extension_prefix, ext_meaningful, operand_width_prefix_bit} = 4'hf;
    vwr(3'h1, 1'b1, XFER_128, ~PA);
    vrd(3'h1, 1'b1);
    chk({rd_a_data, gpr_is_64}, {~PA, 1'b1});
    vrd(3'h1, 1'b0);
    chk(rd_a_data, {PA[127:64], PQ});
    ext_meaningful = 1'b0;
    vrd(3'h1, 1'b1);
    chk(rd_a_data, {PA[127:64], PQ});
    {long_mode, ext_meaningful} = 2'h1;
    vrd(3'h1, 1'b1);
    chk(rd_a_data, {PA[127:64], PQ});
    {mem_access, aligned_packed_move, mem_addr, g} = {2'h3, 64'h8, gpf_cnt};
    vwr(3'h2, 1'b0, XFER_128, PA);
    vrd(3'h2, 1'b0);
    chk({rd_a_data, 32'(gpf_cnt - g)}, {128'h0, 32'h1});
    aligned_packed_move = 1'b0;
    vwr(3'h2, 1'b0, XFER_128, PA);
    vrd(3'h2, 1'b0);
    chk(rd_a_data, PA);
    for (int m = 0; m < 4; m++) begin
      cwr(CSR_RESET | 32'({m[1:0], 13'h0}));
      chk(rounding_control_field, m[1:0]);
    end
    {csr_src, g} = {2'h1, gpf_cnt};
    cwr(32'h0001_9fc0);
    chk({simd_fp_control_status, 32'(gpf_cnt - g)}, {32'h0000_7f80, 32'h1});
    cwr(32'h0000_9fc0);
    chk({flush_to_zero_bit, denormals_as_zero_bit}, 2'h3);
    {csr_src, t} = {2'h0, trap_cnt};
    cwr(CSR_RESET);
    raise(6'h01);
    cwr(32'h0000_1f01);
    raise(6'h20);
    chk({simd_fp_control_status[5:0], 32'(trap_cnt - t)}, {6'h21, 32'h0});
    raise(6'h01);
    chk(32'(trap_cnt - t), 32'h1);
    cwr(32'h0000_9f80);
    raise(6'h10);
    chk({simd_fp_control_status[5:0], 32'(ftz_cnt)}, {6'h30, 32'h1});
    cwr(32'h0000_9780);
    raise(6'h10);
    chk({32'(trap_cnt - t), 32'(ftz_cnt)}, {32'h2, 32'h1});
    cwr(32'h0000_1ec0);
    raise(6'h02);
    chk({simd_fp_control_status[5:0], 32'(trap_cnt - t)}, {6'h00, 32'h2});
    tally_and_finish();
  end
endmodule
